// *** bench/spp_prog_model.sv ***
// Programmer model: makes the serial clock in bursts and drives or releases the data pin.
// Assumes the device drives its data output from rising serial clock edges.
`timescale 1ns/1ps
`default_nettype none
module spp_prog_model (
  output logic sclk,
  output wire logic sdat,
  input wire logic dev_o,
  input wire logic dev_oe
);
  // ****************************************
  // Pin state
  // ****************************************
  logic drv = 1'b1; // High while the programmer drives data
  logic d = 1'b0; // Last value driven
  initial sclk = 1'b0; // Clock rests low between frames
  // Released pin shows the inverse of the last value
  assign sdat = dev_oe ? dev_o : (drv ? d : ~d);
  // One clock cycle: data set while low, sampled just before the fall
  task automatic tick(input logic b, output logic s, output logic oe);
    d = b;
    #3.75 sclk = 1'b1;
    #7 s = sdat;
    oe = dev_oe;
    #0.5 sclk = 1'b0;
    #3.75;
  endtask
  // Six command bits, LSB first, then the gap
  task automatic cmd(input logic [5:0] c);
    logic s;
    logic oe;
    for (int i = 0; i < 6; i++) tick(c[i], s, oe);
    #1000;
  endtask
  // Sixteen-cycle frame: start, fourteen bits LSB first, stop
  task automatic frame(input logic [13:0] w, input logic rd, output logic [13:0] q, output logic [15:0] oev);
    logic s;
    logic oe;
    drv = ~rd;
    for (int k = 1; k <= 16; k++) begin
      tick((k >= 2 && k <= 15) ? w[k-2] : 1'b0, s, oe);
      oev[k-1] = oe;
      if (k >= 2 && k <= 15) q[k-2] = s;
    end
    drv = 1'b1;
    #1000;
  endtask
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench of the serial program port.
// Assumes the programmer model owns the serial pins; this module owns the rest.
`timescale 1ns/1ps
`default_nettype none
module testbench import spp_pkg::*; ;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clk, nrst = 1'b0, mclear = 1'b0, hv = 1'b0, run = 1'b0;
  wire logic sclk, sdat;
  logic sdo, sdoe, prog_mode, prog_act, core_rst_n, port_hz, watchdog_en, reset_is_clear, osc_bad, prot_act;
  logic [11:0] cnt_w;
  logic [2:0] osc_sel;
  int n_mismatch = 0, n_checks = 0, cycles = 0;
  spp_top i_dut (.CLK_SYS(clk), .NRST(nrst), .SERIAL_CLOCK_PIN(sclk), .SERIAL_DATA_PIN_I(sdat),
    .SERIAL_DATA_PIN_O(sdo), .SERIAL_DATA_PIN_OE(sdoe), .MASTER_CLEAR_PIN(mclear), .PROG_HV_PIN(hv),
    .RUN_STEP(run), .PROGRAM_MODE(prog_mode), .PROGRAMMING_ACTIVE(prog_act), .PROGRAM_COUNTER(cnt_w),
    .CORE_RESET_N(core_rst_n), .PORT_HIGH_Z(port_hz), .WATCHDOG_ENABLE(watchdog_en),
    .RESET_PIN_IS_CLEAR(reset_is_clear), .OSC_SELECT(osc_sel), .OSC_INVALID(osc_bad),
    .CODE_PROTECT_ACTIVE(prot_act));
  spp_prog_model i_prog (.sclk(sclk), .sdat(sdat), .dev_o(sdo), .dev_oe(sdoe));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Wait system cycles, then settle just past the edge
  task automatic sys(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic rd(input logic [11:0] exp);
    logic [13:0] q;
    logic [15:0] oev;
    i_prog.cmd(CMD_READ);
    i_prog.frame(14'h0000, 1'b1, q, oev);
    chk("read drive window", 16'h7FFE, oev);
    chk("read word", 16'(exp), 16'(q[11:0]));
  endtask
  // Load, begin, hold the pulse, end
  task automatic wr(input logic [13:0] v);
    logic [13:0] q;
    logic [15:0] oev;
    i_prog.cmd(CMD_LOAD);
    i_prog.frame(v, 1'b0, q, oev);
    i_prog.cmd({1'b0, CMD_BEGIN_LOW});
    chk("pulse running", 16'h1, 16'(prog_act));
    #100000;
    i_prog.cmd(CMD_END);
    chk("pulse stopped", 16'h0, 16'(prog_act));
  endtask
  task automatic steps(input logic [11:0] first, input int n);
    for (int i = 0; i < n; i++) begin
      i_prog.cmd(CMD_INC);
      chk("counter step", 16'(first + 12'(i)), 16'(cnt_w));
    end
  endtask
  task automatic enter(input logic dat);
    i_prog.d = dat;
    mclear = 1'b0;
    hv = 1'b0;
    sys(6);
    chk("counter cleared", 16'hFFF, 16'(cnt_w));
    mclear = 1'b1;
    hv = 1'b1;
    sys(10);
    chk("mode entry", 16'(!dat), 16'(prog_mode));
    #1000;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_entry();
    enter(1'b1);
    enter(1'b0);
    chk("core held", 16'h0, 16'(core_rst_n));
    chk("pins float", 16'h1, 16'(port_hz));
  endtask
  task automatic t_config();
    rd(12'hFFF);
    wr(14'h3FF2);
    rd(12'hFF2);
    chk("watchdog off", 16'h0, 16'(watchdog_en));
    chk("osc crystal", 16'h2, 16'(osc_sel));
    chk("osc valid", 16'h0, 16'(osc_bad));
    chk("clear pin", 16'h1, 16'(reset_is_clear));
    wr(14'h0FDB);
    chk("watchdog on", 16'h1, 16'(watchdog_en));
    chk("osc code", 16'h3, 16'(osc_sel));
    chk("osc invalid", 16'h1, 16'(osc_bad));
    chk("port pin", 16'h0, 16'(reset_is_clear));
    chk("unprotected", 16'h0, 16'(prot_act));
  endtask
  task automatic t_user();
    steps(12'h000, 1);
    wr(14'h0123);
    steps(12'h001, 64);
    wr(14'h0ABC);
    rd(12'hABC);
  endtask
  task automatic t_protect();
    enter(1'b0);
    wr(14'h002F);
    chk("protect on", 16'h1, 16'(prot_act));
    steps(12'h000, 1);
    rd(12'h123);
    steps(12'h001, 64);
    rd(12'h000);
    wr(14'h0555);
    rd(12'h000);
  endtask
  task automatic t_run();
    int i;
    hv = 1'b0;
    sys(10);
    chk("core released", 16'h1, 16'(core_rst_n));
    chk("pins active", 16'h0, 16'(port_hz));
    for (i = 0; i < 5000 && cnt_w !== 12'h3FF; i++) begin
      run = 1'b1;
      sys(1);
      run = 1'b0;
      sys(1);
    end
    chk("run reaches top", 16'h3FF, 16'(cnt_w));
    run = 1'b1;
    sys(1);
    run = 1'b0;
    sys(1);
    chk("run wraps", 16'h000, 16'(cnt_w));
  endtask
  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    #2 nrst = 1'b1;
    t_entry();
    t_config();
    t_user();
    t_protect();
    t_run();
    end_of_test();
  end
endmodule
`default_nettype wire

// *** rtl/spp_link.sv ***
// Serial link end of the program port, clocked by the programmer's clock.
// Assumes the clock rests low while reset releases; data meets the falling edge.
`timescale 1ns/1ps
`default_nettype none
module spp_link import spp_pkg::*; (
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic sdat_i,
  output logic sdat_o,
  output logic sdat_oe,
  spp_link_if.link lnk
);
  // Falling edge state: command and frame receiver
  typedef struct packed {
    spp_phase_e ph;
    logic [4:0] cnt;
    logic [5:0] sh;
    logic is_rd;
    logic [13:0] w;
    logic [5:0] code;
    logic tog;
  } spp_rx_s;
  // Rising edge state: data pin driver
  typedef struct packed {
    logic oe;
    logic dat;
  } spp_tx_s;
  spp_rx_s rx_q;
  spp_rx_s rx_d;
  spp_tx_s tx_q;
  spp_tx_s tx_d;
  logic [13:0] rdw;
  logic [3:0] idx;
  assign rdw = {2'h0, lnk.rd_word};
  assign idx = 4'(rx_q.cnt - DATA_FIRST);
  // Receiver: six command bits, then sixteen frame cycles for load and read
  always_comb begin
    rx_d = rx_q;
    rx_d.cnt = rx_q.cnt + 5'h01;
    case (rx_q.ph)
      SPP_PH_CMD: begin
        rx_d.sh = {sdat_i, rx_q.sh[5:1]};
        if (rx_q.cnt == CMD_LAST_BIT) begin
          rx_d.cnt = 5'h00;
          rx_d.code = rx_d.sh;
          rx_d.is_rd = (rx_d.sh == CMD_READ);
          if (rx_d.sh == CMD_LOAD || rx_d.sh == CMD_READ) begin
            rx_d.ph = SPP_PH_DATA;
          end
          if (rx_d.sh != CMD_LOAD) begin
            rx_d.tog = ~rx_q.tog;
          end
        end
      end
      SPP_PH_DATA: begin
        if (!rx_q.is_rd && rx_q.cnt >= DATA_FIRST && rx_q.cnt <= DATA_LAST) begin
          rx_d.w = {sdat_i, rx_q.w[13:1]};
        end
        if (rx_q.cnt == FRAME_LAST) begin
          rx_d.ph = SPP_PH_CMD;
          rx_d.cnt = 5'h00;
          if (!rx_q.is_rd) begin
            rx_d.tog = ~rx_q.tog;
          end
        end
      end
      default: begin
        rx_d.ph = SPP_PH_CMD;
      end
    endcase
  end
  // Driver: own the pin from rising edge two up to rising edge sixteen
  always_comb begin
    tx_d = '0;
    if (rx_q.ph == SPP_PH_DATA && rx_q.is_rd && rx_q.cnt >= DATA_FIRST && rx_q.cnt <= DATA_LAST) begin
      tx_d.oe = 1'b1;
      tx_d.dat = rdw[idx];
    end
  end
  // Receiver registers on the falling edge
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= '0;
    end else begin
      rx_q <= rx_d;
    end
  end
  // Driver registers on the rising edge
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d;
    end
  end
  assign sdat_o = tx_q.dat;
  assign sdat_oe = tx_q.oe;
  assign lnk.cmd_tog = rx_q.tog;
  assign lnk.cmd_code = rx_q.code;
  assign lnk.load_word = rx_q.w;
  // ************************************************
  // Checks
  // ************************************************
  a_drive_window: assert property (@(negedge sclk) disable iff (!rst_n)
    tx_q.oe |-> rx_q.ph == SPP_PH_DATA && rx_q.is_rd) else $error("data pin driven outside read frame");
  a_drive_start: assert property (@(posedge sclk) disable iff (!rst_n)
    rx_q.ph == SPP_PH_DATA && rx_q.is_rd && rx_q.cnt == DATA_FIRST |=> tx_q.oe) else $error("read not driven");
endmodule
`default_nettype wire

// *** rtl/spp_link_if.sv ***
// Carrier between the serial link logic and the core of the program port.
// Assumes cmd_code and load_word are stable whenever cmd_tog changes.
`timescale 1ns/1ps
`default_nettype none
interface spp_link_if;
  logic cmd_tog;          // Toggles once per finished command
  logic [5:0] cmd_code;   // Code of the last command
  logic [13:0] load_word; // Word of the last load frame
  logic [11:0] rd_word;   // Word shifted out by a read frame
  modport link (output cmd_tog, output cmd_code, output load_word, input rd_word);
  modport core (input cmd_tog, input cmd_code, input load_word, output rd_word);
endinterface
`default_nettype wire

// *** rtl/spp_pkg.sv ***
// Shared constants and types of the serial program port.
// Assumes nothing of its surroundings; spp_link and spp_top import it.
package spp_pkg;
  // ************************************************
  // Word sizes and memory depth
  // ************************************************
  localparam int WORD_W = 32'hC;                  // Memory word width
  localparam int FRAME_W = 32'hE;                 // Data bits in a frame
  localparam int MEM_DEPTH = 32'h404;             // User words plus ID words
  // ************************************************
  // Address map and reset values
  // ************************************************
  localparam logic [11:0] CFG_ADDR = 12'hFFF;     // Configuration word
  localparam logic [11:0] USER_FIRST = 12'h000;   // First user location
  localparam logic [11:0] USER_LAST = 12'h3FF;    // Last user location
  localparam logic [11:0] ID_LAST = 12'h403;      // Last customer ID word
  localparam logic [11:0] PROT_LO = 12'h040;      // First protected word
  localparam logic [11:0] PROT_HI = 12'h3FE;      // Last protected word
  localparam logic [11:0] PC_RESET = 12'hFFF;     // Counter value while cleared
  localparam logic [11:0] CFG_RESET = 12'hFFF;    // Unprogrammed configuration
  // ************************************************
  // Configuration word fields
  // ************************************************
  localparam logic [11:0] CP_MASK = 12'hFD0;      // Code protect copies
  localparam int RESET_PIN_FUNCTION_BIT_BIT = 32'h5;               // Reset pin function bit
  localparam int WATCHDOG_ENABLE_BIT_BIT = 32'h3;                // Watchdog enable bit
  localparam int OSC_LSB = 32'h0;                 // Oscillator select field
  localparam int OSC_W = 32'h3;
  localparam logic [2:0] OSC_BAD = 3'h3;          // Invalid oscillator code
  // ************************************************
  // Commands and frame counts
  // ************************************************
  localparam logic [5:0] CMD_LOAD = 6'h02;
  localparam logic [5:0] CMD_READ = 6'h04;
  localparam logic [5:0] CMD_INC = 6'h06;
  localparam logic [5:0] CMD_END = 6'h0E;
  localparam logic [4:0] CMD_BEGIN_LOW = 5'h08;   // Top bit not decoded
  localparam logic [4:0] CMD_LAST_BIT = 5'h05;    // Sixth command bit
  localparam logic [4:0] DATA_FIRST = 5'h01;      // Frame cycle of data bit 0
  localparam logic [4:0] DATA_LAST = 5'h0E;       // Frame cycle of data bit 13
  localparam logic [4:0] FRAME_LAST = 5'h0F;      // Stop bit cycle
  typedef enum logic {SPP_PH_CMD, SPP_PH_DATA} spp_phase_e;
endpackage

// *** rtl/spp_sync.sv ***
// Three-stage synchroniser; a bit changes once stages two and three agree.
// Assumes inputs are levels that hold for several clock periods.
`timescale 1ns/1ps
`default_nettype none
module spp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // All stages of the chain
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } spp_sync_s;
  spp_sync_s st_q;
  spp_sync_s st_d;
  // Shift the chain; stage one feeds only stage two
  always_comb begin
    st_d = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.q = (~(st_q.s2 ^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.q);
  end
  // Register the chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign q = st_q.q;
endmodule
`default_nettype wire

// *** rtl/spp_top.sv ***
// Serial program/verify port of a one-time-programmable program memory.
// Assumes the programmer makes the serial clock; the pins arrive unsynchronised.
`timescale 1ns/1ps
`default_nettype none
module spp_top import spp_pkg::*; (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic SERIAL_CLOCK_PIN,
  input wire logic SERIAL_DATA_PIN_I,
  output logic SERIAL_DATA_PIN_O,
  output logic SERIAL_DATA_PIN_OE,
  input wire logic MASTER_CLEAR_PIN,
  input wire logic PROG_HV_PIN,
  input wire logic RUN_STEP,
  output logic PROGRAM_MODE,
  output logic PROGRAMMING_ACTIVE,
  output logic [11:0] PROGRAM_COUNTER,
  output logic CORE_RESET_N,
  output logic PORT_HIGH_Z,
  output logic WATCHDOG_ENABLE,
  output logic RESET_PIN_IS_CLEAR,
  output logic [2:0] OSC_SELECT,
  output logic OSC_INVALID,
  output logic CODE_PROTECT_ACTIVE
);
  // ************************************************
  // Declarations
  // ************************************************
  // Core state apart from the memory array in one record
  typedef struct packed {
    logic mode;             // Program/verify mode active
    logic hv_prev;          // High voltage seen last cycle
    logic tog_seen;         // Last command toggle taken
    logic [11:0] pc;        // Program counter
    logic [11:0] latch;     // Word of the last load command
    logic [11:0] cfg;       // Configuration word
    logic prog;             // Programming pulse running
    logic [11:0] rd;        // Word offered to read frames
    logic prot;             // Code protection in force
    logic osc_bad;          // Oscillator code invalid
    logic core_rst_n;       // Rest of the device released
  } spp_core_s;
  spp_core_s st_q;
  spp_core_s st_d;
  logic [WORD_W-1:0] mem_q [MEM_DEPTH]; // User and ID words
  logic [3:0] pin_s;        // Synchronised pins
  logic pin_hv;             // Master clear at programming level
  logic pin_master_clear_pin;           // Master clear logic level
  logic pin_clk;            // Serial clock level
  logic pin_dat;            // Serial data level
  logic tog_s;              // Synchronised command toggle
  logic ev;                 // A command has completed
  logic ev_load;
  logic ev_inc;
  logic ev_begin;
  logic ev_end;
  logic in_array;           // Counter points at a stored word
  logic in_prot;            // Counter points at a locked word
  logic writable;           // Begin programming may write here
  logic [10:0] mem_idx;     // Array index from the counter
  logic [11:0] pc_inc;      // Counter plus one
  logic [11:0] load_low;    // Low part of the loaded frame
  // Reset image of the state; a constant, so the reset branch loads no logic
  localparam spp_core_s CORE_RESET = '{mode: 1'b0, hv_prev: 1'b0, tog_seen: 1'b0, pc: PC_RESET,
                        latch: 12'h000, cfg: CFG_RESET, prog: 1'b0, rd: 12'h000,
                        prot: 1'b0, osc_bad: 1'b0, core_rst_n: 1'b0};
  // ************************************************
  // Pin synchronisers and link
  // ************************************************
  // Pins come from the programmer, outside the system clock
  spp_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .d({PROG_HV_PIN, MASTER_CLEAR_PIN, SERIAL_CLOCK_PIN, SERIAL_DATA_PIN_I}),
    .q(pin_s)
  );
  assign pin_hv = pin_s[3];
  assign pin_master_clear_pin = pin_s[2];
  assign pin_clk = pin_s[1];
  assign pin_dat = pin_s[0];
  // Hazard: the serial pins feed both domains; only the link
  // logic may use the raw levels, the core uses these copies.
  // Entry is judged on the synchronised copies, so a glitch
  // shorter than one system period cannot start the mode.
  // Link carrier between the two clock domains
  spp_link_if lnk ();
  // Only one bit is synchronised; the code and the word ride on it.
  // Command toggle crosses as a level; code and word hold while it settles
  spp_sync #(
    .WIDTH(1)
  ) u_tog_sync (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .d(lnk.cmd_tog),
    .q(tog_s)
  );
  // Link logic is held in reset outside program mode
  // Its reset is the mode flag, so it starts idle on entry.
  spp_link u_link (
    .sclk(SERIAL_CLOCK_PIN),
    .rst_n(st_q.mode),
    .sdat_i(SERIAL_DATA_PIN_I),
    .sdat_o(SERIAL_DATA_PIN_O),
    .sdat_oe(SERIAL_DATA_PIN_OE),
    .lnk(lnk)
  );
  // Read word changes only on commands, so it is stable through a frame
  assign lnk.rd_word = st_q.rd;
  // ************************************************
  // Command decode
  // ************************************************
  // A command counts once its toggle has settled in this domain
  assign ev = st_q.mode && (tog_s != st_q.tog_seen);
  // Each strobe lasts one system cycle, because tog_seen
  // catches up with tog_s at the very next edge.
  // The code word is steady by then: it changed with the
  // toggle and the programmer waits the gap before the next one.
  assign ev_load = ev && (lnk.cmd_code == CMD_LOAD);
  assign ev_inc = ev && (lnk.cmd_code == CMD_INC);
  assign ev_begin = ev && (lnk.cmd_code[4:0] == CMD_BEGIN_LOW);
  assign ev_end = ev && (lnk.cmd_code == CMD_END);
  // Address classes
  // The counter is twelve bits wide, so one step from all
  // ones wraps to zero by plain overflow.
  assign pc_inc = st_q.pc + 12'h001;
  assign mem_idx = st_q.pc[10:0];
  // Words above the last ID word have no storage
  assign in_array = (st_q.pc <= ID_LAST);
  assign in_prot = st_q.prot && (st_q.pc >= PROT_LO) && (st_q.pc <= PROT_HI);
  assign writable = in_array && !in_prot;
  assign load_low = lnk.load_word[WORD_W-1:0];
  // ************************************************
  // Memory array
  // ************************************************
  // No reset on the array, so unwritten words read unknown.
  // Configuration writes go to the state record, not here.
  // Word is written by the begin programming command of a pulse
  always_ff @(posedge CLK_SYS) begin
    if (ev_begin && writable) begin
      mem_q[mem_idx] <= st_q.latch;
    end
  end
  // ************************************************
  // Core next state
  // ************************************************
  always_comb begin
    st_d = st_q;
    st_d.hv_prev = pin_hv;
    st_d.tog_seen = tog_s;
    // Mode entry: rising high voltage with both serial pins low
    // A rise seen with a serial pin high is refused; the link
    // stays in reset until the next clean rise.
    if (pin_hv && !st_q.hv_prev && !pin_clk && !pin_dat) begin
      st_d.mode = 1'b1;
    end else if (!pin_hv) begin
      st_d.mode = 1'b0;
    end
    // Program counter
    // Clear wins over any command; the counter stays all ones
    if (!pin_master_clear_pin) begin
      st_d.pc = PC_RESET;
    end else if (ev_inc) begin
      if (pc_inc == CFG_ADDR) begin
        st_d.pc = USER_FIRST;
      end else begin
        st_d.pc = pc_inc;
      end
    end else if (st_q.core_rst_n && RUN_STEP) begin
      // Normal run wraps at the last user word; values above it
      // left over from program mode wrap as well
      if (st_q.pc >= USER_LAST) begin
        st_d.pc = USER_FIRST;
      end else begin
        st_d.pc = pc_inc;
      end
    end
    // Load keeps the twelve low bits of the fourteen
    if (ev_load) begin
      st_d.latch = load_low;
    end
    // Programming pulse from begin to end command
    // Begin sets the flag even where the write is refused,
    // so the programmer sees the same pulse timing everywhere.
    if (ev_begin) begin
      st_d.prog = 1'b1;
      if (st_q.pc == CFG_ADDR) begin
        st_d.cfg = st_q.latch;
      end
    end
    if (ev_end || !st_q.mode) begin
      st_d.prog = 1'b0;
    end
    // Word offered to the next read frame
    // Refreshed every cycle; it moves only when the counter, the stored words,
    // the configuration word or the protection flag move, which happens between frames.
    if (st_q.pc == CFG_ADDR) begin
      st_d.rd = st_q.cfg;
    end else if (in_prot || !in_array) begin
      st_d.rd = 12'h000;
    end else begin
      st_d.rd = mem_q[mem_idx];
    end
    // Protection needs every copy programmed to zero
    st_d.prot = ((st_q.cfg & CP_MASK) == 12'h000);
    st_d.osc_bad = (st_q.cfg[OSC_LSB +: OSC_W] == OSC_BAD);
    // Rest of the device waits in reset during program mode
    // Leaving the mode releases the core one cycle later
    if (st_q.mode || pin_hv) begin
      st_d.core_rst_n = 1'b0;
    end else if (st_q.cfg[RESET_PIN_FUNCTION_BIT_BIT]) begin
      st_d.core_rst_n = pin_master_clear_pin;
    end else begin
      st_d.core_rst_n = 1'b1;
    end
  end
  // ************************************************
  // Core registers
  // ************************************************
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      st_q <= CORE_RESET;
    end else begin
      st_q <= st_d;
    end
  end
  // ************************************************
  // Outputs
  // ************************************************
  // All outputs come straight from registers; PORT_HIGH_Z
  // is the only one with an inverter in front.
  assign PROGRAM_MODE = st_q.mode;
  assign PROGRAMMING_ACTIVE = st_q.prog;
  assign PROGRAM_COUNTER = st_q.pc;
  assign CORE_RESET_N = st_q.core_rst_n;
  assign PORT_HIGH_Z = ~st_q.core_rst_n;
  assign WATCHDOG_ENABLE = st_q.cfg[WATCHDOG_ENABLE_BIT_BIT];
  assign RESET_PIN_IS_CLEAR = st_q.cfg[RESET_PIN_FUNCTION_BIT_BIT];
  assign OSC_SELECT = st_q.cfg[OSC_LSB +: OSC_W];
  assign OSC_INVALID = st_q.osc_bad;
  assign CODE_PROTECT_ACTIVE = st_q.prot;
  // ************************************************
  // Checks
  // ************************************************
  // All core checks run on the system clock and stop in reset
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  // Clean rise of the high voltage enters the mode
  a_mode_entry: assert property (
    pin_hv && !st_q.hv_prev && !pin_clk && !pin_dat |=> st_q.mode) else $error("mode entry missed");
  // Clear forces the counter to all ones
  a_pc_forced_ones: assert property (
    !pin_master_clear_pin |=> st_q.pc == CFG_ADDR) else $error("counter not all ones while cleared");
  // One step from all ones lands on zero
  a_pc_wrap_zero: assert property (
    pin_master_clear_pin && ev_inc && st_q.pc == CFG_ADDR |=> st_q.pc == USER_FIRST) else $error("no wrap to zero");
  // Stepping never lands on the configuration word
  a_cfg_not_again: assert property (
    pin_master_clear_pin && st_q.pc != CFG_ADDR |=> st_q.pc != CFG_ADDR) else $error("config reached by stepping");
  // Normal run wraps at the last user word
  a_normal_wrap: assert property (
    pin_master_clear_pin && !ev_inc && st_q.core_rst_n && RUN_STEP && st_q.pc == USER_LAST |=> st_q.pc == USER_FIRST)
    else $error("normal run did not wrap");
  // Increment command adds one
  a_inc_step: assert property (
    pin_master_clear_pin && ev_inc && st_q.pc < 12'hFFE |=> st_q.pc == $past(pc_inc)) else $error("increment lost");
  // Load keeps the low twelve bits
  a_load_latch: assert property (
    ev_load |=> st_q.latch == $past(load_low)) else $error("load word not kept");
  // Latch only moves on a load
  a_latch_hold: assert property (
    !ev_load |=> st_q.latch == $past(st_q.latch)) else $error("latch moved without load");
  // Pulse runs until the end command
  a_pulse_holds: assert property (
    ev_begin ##1 (st_q.mode && !ev_end) [*2] |-> st_q.prog) else $error("pulse ended early");
  // End command stops the pulse
  a_pulse_stops: assert property (
    ev_end |=> !st_q.prog) else $error("pulse not stopped");
  // Leaving the mode ends a pulse too
  a_exit_stops: assert property (
    !st_q.mode |=> !st_q.prog) else $error("pulse outlived the mode");
  // Locked words read zero
  a_prot_zero: assert property (
    in_prot |=> st_q.rd == 12'h000) else $error("locked word leaked");
  // Protection follows the code protect copies
  a_prot_flag: assert property (
    (st_q.cfg & CP_MASK) == 12'h000 |=> CODE_PROTECT_ACTIVE) else $error("protection not in force");
  // Configuration word is offered at the top address
  a_read_config: assert property (
    st_q.pc == CFG_ADDR |=> st_q.rd == $past(st_q.cfg)) else $error("config word not offered");
  // Begin at the top address replaces the configuration word
  a_cfg_write: assert property (
    ev_begin && st_q.pc == CFG_ADDR |=> st_q.cfg == $past(st_q.latch)) else $error("config word not written");
  // Invalid oscillator code is flagged
  a_osc_invalid: assert property (
    st_q.cfg[OSC_LSB +: OSC_W] == OSC_BAD |=> OSC_INVALID) else $error("invalid oscillator unflagged");
  // Core stays in reset during the mode
  a_core_held: assert property (
    st_q.mode |=> !CORE_RESET_N && PORT_HIGH_Z) else $error("core ran in program mode");
  // Data pin floats outside the mode
  a_pin_released: assert property (
    !st_q.mode |=> !SERIAL_DATA_PIN_OE) else $error("data pin driven outside mode");
  // Clear tied inactive when the pin is a port pin
  a_clear_tied: assert property (
    !st_q.cfg[RESET_PIN_FUNCTION_BIT_BIT] && !st_q.mode && !pin_hv && !ev_begin |=> CORE_RESET_N) else $error("clear not tied");
  // Main scenarios: load, pulse, read, wrap, refused write
  c_load: cover property (ev_load);
  c_pulse: cover property (ev_begin ##1 st_q.prog);
  c_refused: cover property (ev_begin && in_prot);
  c_read_drive: cover property (st_q.mode && SERIAL_DATA_PIN_OE);
  c_wrap: cover property (ev_inc && st_q.pc == CFG_ADDR);
endmodule
`default_nettype wire
